//--- bench/disp_acq_mem.sv
`timescale 1ns/100ps
`default_nettype none
`include "disp_regs.svh"

// Acquisition memory model: keeps up to 256 packed words in arrival order, then wraps
module disp_acq_mem #(
   parameter int NCH = 2
) (
   input  wire logic                        i_clk,
   input  wire logic                        i_rst,
   input  wire logic                        i_valid,
   input  wire logic [NCH*`DISP_WORD_W-1:0] i_word,
   input  wire logic [7:0]                  i_rd_adr,
   output var  logic [NCH*`DISP_WORD_W-1:0] o_rd_dat,
   output var  logic [7:0]                  o_count
);
   logic [NCH*`DISP_WORD_W-1:0] mem_r [256];
   logic [7:0]                  cnt_r;

   // No back-pressure exists, so a word is taken on every strobe
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_r <= 8'h00;
      end else if (i_valid) begin
         mem_r[cnt_r] <= i_word;
         cnt_r        <= cnt_r + 8'h01;
      end
   end

   // Readback port for the bench
   assign o_rd_dat = mem_r[i_rd_adr];
   assign o_count  = cnt_r;
endmodule

`default_nettype wire

//--- bench/disp_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "disp_regs.svh"

module disp_top_tb;
   import disp_pkg::*;
   logic          clk  = 1'h0;
   logic          rst  = 1'h1;
   logic          cyc  = 1'h0;
   logic          stb  = 1'h0;
   logic          we   = 1'h0;
   disp_adr_type  adr  = 20'h00000;
   disp_sel_type  sel  = 4'h0;
   disp_data_type wdat = 32'h0;
   logic          opt  = 1'h0;
   logic          run  = 1'h0;
   logic          sv   = 1'h0;
   logic [23:0]   ana  = 24'h0;
   logic [7:0]    nib  = 8'h0;
   logic [7:0]    madr = 8'h0;
   disp_data_type rdat;
   disp_data_type dat_o;
   logic          ack;
   logic          smp_v;
   logic          fmt;
   logic [31:0]   word;
   logic [31:0]   mem_dat;
   logic [7:0]    mcnt;
   logic [7:0]    last_nib;
   int            num_errors = 0;
   int            checked    = 0;
   int            cycles     = 0;
   int            n          = 0;
   logic [23:0]   atab [4]   = '{24'h8007ff, 24'h7ff800, 24'h000fff, 24'hfff001};
   logic [7:0]    ntab [4]   = '{8'h5a, 8'hc3, 8'h0f, 8'h96};

   // Free-running 250 MHz clock
   always #2 clk = ~clk;

   disp_top #(.NCH(2), .DIG_LAG_SMP(1)) u_dut (
      .I_SYS_CLK               (clk),
      .I_RST                   (rst),
      .I_WB_CYC                (cyc),
      .I_WB_STB                (stb),
      .I_WB_WE                 (we),
      .I_WB_ADR                (adr),
      .I_WB_SEL                (sel),
      .I_WB_DAT                (wdat),
      .O_WB_DAT                (dat_o),
      .O_WB_ACK                (ack),
      .I_OPT_FITTED            (opt),
      .I_ACQ_RUN               (run),
      .I_SMP_VALID             (sv),
      .I_ANALOG_CHANNEL_SAMPLE (ana),
      .I_DIGITAL_INPUT_NIBBLE  (nib),
      .O_SMP_VALID             (smp_v),
      .O_SMP_WORD              (word),
      .O_FMT_DIG               (fmt)
   );

   disp_acq_mem #(.NCH(2)) u_mem (
      .i_clk    (clk),
      .i_rst    (rst),
      .i_valid  (smp_v),
      .i_word   (word),
      .i_rd_adr (madr),
      .o_rd_dat (mem_dat),
      .o_count  (mcnt)
   );

   task automatic chk_word(input disp_data_type got, input disp_data_type exp, input string m);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string m);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %b exp %b", $time, m, got, exp);
      end
   endtask

   // Classic single cycle; ack and read data are taken at the same edge
   task automatic wb(input logic w, input disp_adr_type a, input disp_sel_type s,
                     input disp_data_type d);
      int k;
      k = 0;
      @(posedge clk);
      cyc  <= 1'h1;
      stb  <= 1'h1;
      we   <= w;
      adr  <= a;
      sel  <= s;
      wdat <= d;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'h1 && k < 50);
      rdat = dat_o;
      chk_bit(ack, 1'h1, "bus ack");
      cyc <= 1'h0;
      stb <= 1'h0;
      we  <= 1'h0;
   endtask

   task automatic rd_chk(input disp_adr_type a, input disp_data_type exp, input string m);
      wb(1'h0, a, 4'hf, 32'h0);
      chk_word(rdat, exp, m);
   endtask

   // One strobe; the nibble used is the one on the pins at the previous strobe
   task automatic smp(input logic [23:0] a, input logic [7:0] nx, input logic f);
      disp_data_type exp;
      exp = {f ? last_nib[7:4] : {4{a[23]}}, a[23:12], f ? last_nib[3:0] : {4{a[11]}}, a[11:0]};
      @(posedge clk);
      sv  <= 1'h1;
      ana <= a;
      @(posedge clk);
      sv <= 1'h0;
      @(posedge clk);
      madr <= n[7:0];
      @(posedge clk);
      chk_word(mem_dat, exp, "stored word");
      n++;
      last_nib = nib;
      nib <= nx;
      repeat (8) @(posedge clk);
   endtask

   task automatic results;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Hang guard, far above the roughly 170 cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles > 3000) begin
         num_errors++;
         $display("wrong value at %0t: timeout", $time);
         results();
      end
   end

   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      rd_chk(`DISP_ADR_DIG_EN, 32'h0, "enable reset");
      rd_chk(`DISP_ADR_STATUS, 32'h0, "status reset");
      rd_chk(20'h00100, 32'h0, "unmapped read");
      wb(1'h1, `DISP_ADR_DIG_EN, 4'hf, 32'h1);
      rd_chk(`DISP_ADR_DIG_EN, 32'h0, "enable without option");
      for (int i = 0; i < 4; i++)
         smp(atab[i], ntab[i], 1'h0);
      opt <= 1'h1;
      repeat (6) @(posedge clk);
      rd_chk(`DISP_ADR_STATUS, 32'h1, "option seen");
      wb(1'h1, `DISP_ADR_DIG_EN, 4'h0, 32'h1);
      rd_chk(`DISP_ADR_DIG_EN, 32'h0, "lane off write");
      wb(1'h1, `DISP_ADR_DIG_EN, 4'hf, 32'h1);
      rd_chk(`DISP_ADR_DIG_EN, 32'h1, "enable set");
      repeat (2) @(posedge clk);
      chk_bit(fmt, 1'h1, "format idle follows");
      run <= 1'h1;
      wb(1'h1, `DISP_ADR_DIG_EN, 4'hf, 32'h0);
      rd_chk(`DISP_ADR_DIG_EN, 32'h0, "enable cleared");
      rd_chk(`DISP_ADR_STATUS, 32'h7, "status in run");
      for (int i = 0; i < 4; i++)
         smp(atab[i], ntab[3-i], 1'h1);
      chk_bit(fmt, 1'h1, "format held in run");
      run <= 1'h0;
      repeat (3) @(posedge clk);
      chk_bit(fmt, 1'h0, "format after run");
      wb(1'h1, `DISP_ADR_DIG_EN, 4'hf, 32'h1);
      rd_chk(`DISP_ADR_DIG_EN, 32'h1, "enable set again");
      opt <= 1'h0;
      repeat (6) @(posedge clk);
      rd_chk(`DISP_ADR_DIG_EN, 32'h0, "enable lost with option");
      rd_chk(`DISP_ADR_STATUS, 32'h0, "status option lost");
      chk_word({24'h0, mcnt}, 32'h8, "words stored");
      results();
   end
endmodule

`default_nettype wire

//--- core/disp_lane_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "disp_regs.svh"

// Sample lane between the bus and pin side and the packer
interface disp_lane_if #(
   parameter int NCH = 2
);
   logic                           smp_valid;
   logic [NCH*`DISP_ADC_W-1:0]     analog;
   logic [NCH*`DISP_NIB_W-1:0]     nibble;
   logic                           fmt_dig;
   logic                           word_valid;
   logic [NCH*`DISP_WORD_W-1:0]    word;

   modport feed (
      output smp_valid,
      output analog,
      output nibble,
      output fmt_dig,
      input  word_valid,
      input  word
   );
   modport pack (
      input  smp_valid,
      input  analog,
      input  nibble,
      input  fmt_dig,
      output word_valid,
      output word
   );
endinterface

`default_nettype wire

//--- core/disp_packer.sv
`timescale 1ns/100ps
`default_nettype none
`include "disp_regs.svh"

module disp_packer #(
   parameter int NCH         = 2,
   parameter int DIG_LAG_SMP = 1
) (
   input  wire logic   clk,
   input  wire logic   rst,
   disp_lane_if.pack   lane
);
   import disp_pkg::*;

   localparam int NIB_W  = NCH*`DISP_NIB_W;
   localparam int WORD_W = NCH*`DISP_WORD_W;
   localparam int IDX_W  = (DIG_LAG_SMP > 1) ? $clog2(DIG_LAG_SMP) : 1;

   logic [NIB_W-1:0]   ring_r [DIG_LAG_SMP];
   logic [IDX_W-1:0]   idx_r;
   logic               valid_r;
   logic [WORD_W-1:0]  word_r;
   wire  [WORD_W-1:0]  word_nxt;
   wire  [NIB_W-1:0]   nib_old;
   wire                idx_last;

   // Oldest entry of the ring: fixed lag in samples, never in time
   assign nib_old  = ring_r[idx_r];
   assign idx_last = (idx_r == IDX_W'(DIG_LAG_SMP-1));

   // Word build per channel; upper nibble is either sign or pins
   for (genvar c = 0; c < NCH; c++) begin : g_ch
      wire [`DISP_ADC_W-1:0] a = lane.analog[c*`DISP_ADC_W +: `DISP_ADC_W];
      wire [`DISP_NIB_W-1:0] d = nib_old[c*`DISP_NIB_W +: `DISP_NIB_W];
      assign word_nxt[c*`DISP_WORD_W +: `DISP_WORD_W] =
         {(lane.fmt_dig ? d : {`DISP_NIB_W{a[`DISP_ADC_MSB]}}), a};
   end

   // Delay ring is data only, so it carries no reset
   always_ff @(posedge clk) begin
      if (lane.smp_valid) begin
         ring_r[idx_r] <= lane.nibble;
      end
   end

   // Word register and ring pointer move only on a sample strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         idx_r   <= '0;
         valid_r <= 1'b0;
         word_r  <= '0;
      end else begin
         valid_r <= lane.smp_valid;
         if (lane.smp_valid) begin
            idx_r  <= idx_last ? '0 : idx_r + IDX_W'(1);
            word_r <= word_nxt;
         end
      end
   end

   assign lane.word_valid = valid_r;
   assign lane.word       = word_r;

   // Helper copies of the channel 0 inputs for the checks below
   logic                  fmt_q;
   logic [`DISP_ADC_W-1:0] a0_q;
   logic [`DISP_NIB_W-1:0] d0_q;
   always_ff @(posedge clk) begin
      if (lane.smp_valid) begin
         fmt_q <= lane.fmt_dig;
         a0_q  <= lane.analog[`DISP_ADC_W-1:0];
         d0_q  <= nib_old[`DISP_NIB_W-1:0];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_word_follows_smp: assert property (lane.smp_valid |=> valid_r)
      else $error("word strobe missing after sample");
   a_no_stray_word: assert property (!lane.smp_valid |=> !valid_r)
      else $error("word strobe without sample");
   a_low_bits_kept: assert property (valid_r |-> word_r[`DISP_ADC_W-1:0] == a0_q)
      else $error("converter bits not kept in low word");
   a_sign_ext_nibble: assert property (valid_r && !fmt_q |->
      word_r[`DISP_WORD_W-1:`DISP_ADC_W] == {`DISP_NIB_W{a0_q[`DISP_ADC_MSB]}})
      else $error("upper nibble not sign extended");
   a_dig_nibble: assert property (valid_r && fmt_q |->
      word_r[`DISP_WORD_W-1:`DISP_ADC_W] == d0_q)
      else $error("upper nibble not digital input");
   a_ring_bounded: assert property (idx_r <= IDX_W'(DIG_LAG_SMP-1))
      else $error("delay ring pointer out of range");
endmodule

`default_nettype wire

//--- core/disp_pkg.sv
`default_nettype none
`include "disp_regs.svh"

package disp_pkg;
   // Bus data and address carriers
   typedef logic [31:0]              disp_data_type;
   typedef logic [`DISP_ADR_W-1:0]   disp_adr_type;
   typedef logic [3:0]               disp_sel_type;
   // Acquisition phase as seen by the format latch
   typedef enum logic {ACQ_IDLE, ACQ_RUN} disp_acq_type;
endpackage

`default_nettype wire

//--- core/disp_regs.svh
`ifndef DISP_REGS_SVH
`define DISP_REGS_SVH

// Register byte addresses on the bus
`define DISP_ADR_W          20
`define DISP_ADR_DIG_EN     20'h1ae14
`define DISP_ADR_STATUS     20'h1ae18
`define DISP_ADR_LSB        2

// Field positions
`define DISP_EN_BIT         0
`define DISP_ST_OPT         0
`define DISP_ST_ACQ         1
`define DISP_ST_FMT         2
`define DISP_EN_LANE        0

// Reset values
`define DISP_EN_RST         1'b0

// Sample layout
`define DISP_ADC_W          12
`define DISP_NIB_W          4
`define DISP_WORD_W         16
`define DISP_ADC_MSB        11

`endif

//--- core/disp_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "disp_regs.svh"


module disp_top #(
   parameter int NCH         = 2,
   parameter int DIG_LAG_SMP = 1
) (
   input  wire logic                        I_SYS_CLK,
   input  wire logic                        I_RST,
   input  wire logic                        I_WB_CYC,
   input  wire logic                        I_WB_STB,
   input  wire logic                        I_WB_WE,
   input  wire disp_pkg::disp_adr_type      I_WB_ADR,
   input  wire disp_pkg::disp_sel_type      I_WB_SEL,
   input  wire disp_pkg::disp_data_type     I_WB_DAT,
   output var  disp_pkg::disp_data_type     O_WB_DAT,
   output var  logic                        O_WB_ACK,
   input  wire logic                        I_OPT_FITTED,
   input  wire logic                        I_ACQ_RUN,
   input  wire logic                        I_SMP_VALID,
   input  wire logic [NCH*`DISP_ADC_W-1:0]  I_ANALOG_CHANNEL_SAMPLE,
   input  wire logic [NCH*`DISP_NIB_W-1:0]  I_DIGITAL_INPUT_NIBBLE,
   output var  logic                        O_SMP_VALID,
   output var  logic [NCH*`DISP_WORD_W-1:0] O_SMP_WORD,
   output var  logic                        O_FMT_DIG
);
   import disp_pkg::*;

   localparam int NIB_W = NCH*`DISP_NIB_W;
   localparam int ADR_W = `DISP_ADR_W;

   // Word-aligned address match, used for every register
   function automatic logic adr_hit(input disp_adr_type a, input disp_adr_type off);
      return a[ADR_W-1:`DISP_ADR_LSB] == off[ADR_W-1:`DISP_ADR_LSB];
   endfunction

   // Pin synchronisers and their filtered results
   logic [NIB_W-1:0] nib_s1_r;
   logic [NIB_W-1:0] nib_s2_r;
   logic [NIB_W-1:0] nib_s3_r;
   logic [NIB_W-1:0] nib_r;
   wire  [NIB_W-1:0] nib_nxt;
   logic             opt_s1_r;
   logic             opt_s2_r;
   logic             opt_s3_r;
   logic             opt_r;
   wire              opt_nxt;

   // Register and control state
   logic             en_r;
   logic             en_nxt;
   disp_acq_type     acq_r;
   disp_acq_type     acq_nxt;
   logic             fmt_r;
   logic             fmt_nxt;
   logic             ack_r;
   disp_data_type    rd_r;
   disp_data_type    rd_nxt;
   disp_data_type    st_word;

   // Bus decode
   wire bus_req = I_WB_CYC & I_WB_STB & ~ack_r;
   wire wr_req  = I_WB_CYC & I_WB_STB & I_WB_WE & ack_r; // Write lands on the ack edge
   wire hit_en  = adr_hit(I_WB_ADR, `DISP_ADR_DIG_EN);
   wire hit_st  = adr_hit(I_WB_ADR, `DISP_ADR_STATUS);
   wire wr_en   = wr_req & hit_en & I_WB_SEL[`DISP_EN_LANE];

   // A bit moves only when stages two and three agree, so a glitch
   // caught by stage one alone never reaches the sample word
   assign nib_nxt = (nib_s2_r & nib_s3_r) | (nib_r & (nib_s2_r | nib_s3_r));
   assign opt_nxt = (opt_s2_r & opt_s3_r) | (opt_r & (opt_s2_r | opt_s3_r));

   // Three-stage sync of the digital pins and the option strap
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         nib_s1_r <= '0;
         nib_s2_r <= '0;
         nib_s3_r <= '0;
         nib_r    <= '0;
      end else begin
         nib_s1_r <= I_DIGITAL_INPUT_NIBBLE;
         nib_s2_r <= nib_s1_r;
         nib_s3_r <= nib_s2_r;
         nib_r    <= nib_nxt;
      end
   end

   // Strap is caught after reset release, never during it
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         opt_s1_r <= 1'b0;
         opt_s2_r <= 1'b0;
         opt_s3_r <= 1'b0;
         opt_r    <= 1'b0;
      end else begin
         opt_s1_r <= I_OPT_FITTED;
         opt_s2_r <= opt_s1_r;
         opt_s3_r <= opt_s2_r;
         opt_r    <= opt_nxt;
      end
   end

   // Enable: cleared and locked at zero while no option is fitted
   always_comb begin
      if (!opt_r) begin
         en_nxt = 1'b0;
      end else if (wr_en) begin
         en_nxt = I_WB_DAT[`DISP_EN_BIT];
      end else begin
         en_nxt = en_r;
      end
   end

   // Acquisition phase from the run level
   always_comb begin
      case (acq_r)
         ACQ_IDLE: acq_nxt = I_ACQ_RUN ? ACQ_RUN : ACQ_IDLE;
         ACQ_RUN:  acq_nxt = I_ACQ_RUN ? ACQ_RUN : ACQ_IDLE;
         default:  acq_nxt = ACQ_IDLE;
      endcase
   end

   // Format follows the enable when idle, frozen for a whole run so
   // one record never mixes two layouts
   assign fmt_nxt = (acq_r == ACQ_RUN && acq_nxt == ACQ_RUN) ? fmt_r : en_r;

   // Status word: option, run phase, active format
   assign st_word = (disp_data_type'(opt_r) << `DISP_ST_OPT)
                  | (disp_data_type'(acq_r == ACQ_RUN) << `DISP_ST_ACQ)
                  | (disp_data_type'(fmt_r) << `DISP_ST_FMT);

   // Read mux; unmapped addresses read zero and still get an ack
   assign rd_nxt = I_WB_WE ? '0
                 : hit_en  ? (disp_data_type'(en_r) << `DISP_EN_BIT)
                 : hit_st  ? st_word
                 : '0;

   // Control registers
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         en_r  <= `DISP_EN_RST;
         acq_r <= ACQ_IDLE;
         fmt_r <= `DISP_EN_RST;
      end else begin
         en_r  <= en_nxt;
         acq_r <= acq_nxt;
         fmt_r <= fmt_nxt;
      end
   end

   // Single-wait-state slave: ack one edge after the request, for one cycle
   always_ff @(posedge I_SYS_CLK) begin
      if (I_RST) begin
         ack_r <= 1'b0;
         rd_r  <= '0;
      end else begin
         ack_r <= bus_req;
         if (bus_req) begin
            rd_r <= rd_nxt;
         end
      end
   end

   assign O_WB_ACK  = ack_r;
   assign O_WB_DAT  = rd_r;
   assign O_FMT_DIG = fmt_r;

   // Sample lane into the packer
   disp_lane_if #(.NCH(NCH)) lane ();

   assign lane.smp_valid = I_SMP_VALID;
   assign lane.analog    = I_ANALOG_CHANNEL_SAMPLE;
   assign lane.nibble    = nib_r;
   assign lane.fmt_dig   = fmt_r;

   disp_packer #(
      .NCH         (NCH),
      .DIG_LAG_SMP (DIG_LAG_SMP)
   ) u_packer (
      .clk  (I_SYS_CLK),
      .rst  (I_RST),
      .lane (lane)
   );

   // Packer outputs are its own flip-flops
   assign O_SMP_VALID = lane.word_valid;
   assign O_SMP_WORD  = lane.word;

   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (I_RST);

   a_ack_after_req: assert property (I_WB_CYC && I_WB_STB && !ack_r |=> ack_r)
      else $error("bus request not acknowledged next cycle");
   a_ack_single: assert property (ack_r |=> !ack_r)
      else $error("ack held longer than one cycle");
   a_en_write: assert property (wr_en && opt_r && I_WB_DAT[`DISP_EN_BIT] |=> en_r)
      else $error("enable write not stored");
   a_en_unfitted: assert property (!opt_r |=> !en_r)
      else $error("enable set without option fitted");
   a_en_readback: assert property (bus_req && !I_WB_WE && hit_en |=>
      O_WB_DAT[`DISP_EN_BIT] == $past(en_r))
      else $error("enable readback wrong");
   a_fmt_held_run: assert property (acq_r == ACQ_RUN ##1 acq_r == ACQ_RUN |->
      $stable(fmt_r))
      else $error("format changed during acquisition");
   a_fmt_start_latch: assert property (acq_r == ACQ_IDLE && I_ACQ_RUN |=>
      fmt_r == $past(en_r))
      else $error("format not latched at start");
   a_fmt_needs_opt: assert property (acq_r == ACQ_IDLE ##1 fmt_r |-> $past(opt_r, 2))
      else $error("digital format without option");
endmodule

`default_nettype wire
